//--- status_sel_regs.svh
// Register map and constants of the status output selector
`ifndef STATUS_SEL_REGS_SVH
`define STATUS_SEL_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_FREQ 12'h004
`define REG_COUNT 12'h008
`define REG_STAT 12'h00c
`define REG_IRQ_STAT 12'h010
`define REG_IRQ_MASK 12'h014

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_SEL1_LSB 0
`define CTRL_SEL2_LSB 4
`define CTRL_RELAY_LSB 8
`define SEL1_RESET 4'h0
`define SEL2_RESET 4'h1
`define RELAY_RESET 3'h0
`define FREQ_RESET 12'h000
`define FREQ_MAX 12'hfa0
`define COUNT_RESET 14'h0001
`define COUNT_MAX 14'h270f
`define COUNT_DONE 14'h0001
`define OUT_CODE_MAX 4'h9
`define RELAY_CODE_MAX 3'h6

`endif

//--- status_sel_pkg.sv
// Types shared by the status output selector
package status_sel_pkg;

  // Indexes of the condition vector
  typedef enum logic [3:0] {
    cond_running = 4'h0,
    cond_freq_reached = 4'h1,
    cond_desired = 4'h2,
    cond_count_done = 4'h3,
    cond_nonzero = 4'h4,
    cond_torque = 4'h5,
    cond_blocked = 4'h6,
    cond_low_volt = 4'h7,
    cond_remote = 4'h8,
    cond_fault = 4'h9
  } cond_e;

  // Bus slave states, Gray along the path
  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_resp = 2'b01
  } bus_e;

endpackage : status_sel_pkg

//--- count_sync.sv
// Three-stage synchroniser with an agreed-edge pulse for the trigger pin
module count_sync
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pin and clean rising-edge pulse
  input wire logic pin,
  output logic rise
);

  // Synchroniser chain and settled level
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } sync_s;

  sync_s state;
  sync_s next_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The level moves only when stages two and three agree
  always_comb
  begin
    next_state = state;
    next_state.s1 = pin;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    next_state.rise = 1'b0;
    if (state.s2 == state.s3 && state.s3 != state.level)
    begin
      next_state.level = state.s3;
      next_state.rise = state.s3;
    end
  end

  // Register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= '0;
    else
      state <= next_state;
  end

  assign rise = state.rise;

endmodule : count_sync

//--- status_output_selector.sv
// Status output selector with AXI4-Lite registers and countdown counter
`include "status_sel_regs.svh"

// How it works
// - Two outputs, codes 0-9, reset 0 and 1
// - Code 0: producing output or run command
// - Code 1: output reached commanded frequency
// - Code 2: output reached desired setpoint
// - Setpoint 0.1 Hz steps, 0-400.0, reset 0
// - Code 3: trigger countdown reached one
// - Code 4: frequency above minimum setting
// - Code 5: follows over-torque flag
// - Code 6: closed while output blocked
// - Code 7: closed while low voltage
// - Code 8: closed when remotely commanded
// - Code 9: closed while fault latched
// - Relay codes 0-6, complementary contacts
// - Fault indication off during restart
// - Counter reloads start value after completion
module status_output_selector #(
  parameter int FREQ_W = 12
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive condition inputs, same clock
  input wire logic [FREQ_W-1:0] output_freq,
  input wire logic [FREQ_W-1:0] command_freq,
  input wire logic [FREQ_W-1:0] min_output_freq_setting,
  input wire logic output_active,
  input wire logic forward_run_cmd,
  input wire logic reverse_run_cmd,
  input wire logic over_torque,
  input wire logic output_blocked,
  input wire logic low_voltage,
  input wire logic remote_mode,
  input wire logic fault_latched,
  input wire logic restart_active,
  // External trigger pin
  input wire logic count_trigger_input,
  // Status and relay outputs
  output logic status_output_one,
  output logic status_output_two,
  output logic relay_normally_open_contact,
  output logic relay_normally_closed_contact,
  output logic irq
);

  // Refuse widths that cannot hold 400.0 Hz in tenths
  if (FREQ_W < 12 || FREQ_W > 16)
    $error("FREQ_W must be 12 to 16");

  localparam int NCOND = 10;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    status_sel_pkg::bus_e wstate;
    status_sel_pkg::bus_e rstate;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] rdata;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [3:0] sel1;
    logic [3:0] sel2;
    logic [2:0] relay_sel;
    logic [11:0] desired_freq_setpoint;
    logic [13:0] count_start;
    logic [13:0] counter;
    logic count_done;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic out1;
    logic out2;
    logic relay;
    logic [NCOND-1:0] cond_q;
  } sel_s;

  sel_s state;
  sel_s next_state;

  // Condition vector indexed by selector code
  logic [NCOND-1:0] cond;
  // Trigger pulse after synchronising
  logic trig_rise;
  // Write strobe decoded
  logic do_write;
  logic [31:0] wmask;
  logic [FREQ_W-1:0] desired_wide;

  // ----------------------------------------------------------------
  // Trigger synchroniser
  // ----------------------------------------------------------------
  count_sync u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(count_trigger_input),
    .rise(trig_rise)
  );

  assign desired_wide = FREQ_W'(state.desired_freq_setpoint);

  // ----------------------------------------------------------------
  // Condition vector
  // ----------------------------------------------------------------
  // Conditions are built from the same-clock flags
  always_comb
  begin
    cond = '0;
    cond[status_sel_pkg::cond_running] = output_active | forward_run_cmd
      | reverse_run_cmd;
    cond[status_sel_pkg::cond_freq_reached] = output_freq == command_freq;
    cond[status_sel_pkg::cond_desired] = output_freq >= desired_wide;
    cond[status_sel_pkg::cond_count_done] = state.count_done;
    cond[status_sel_pkg::cond_nonzero] =
      output_freq > min_output_freq_setting;
    cond[status_sel_pkg::cond_torque] = over_torque;
    cond[status_sel_pkg::cond_blocked] = output_blocked;
    cond[status_sel_pkg::cond_low_volt] = low_voltage;
    cond[status_sel_pkg::cond_remote] = remote_mode;
    cond[status_sel_pkg::cond_fault] = fault_latched & ~restart_active;
  end

  assign do_write = state.aw_got && state.w_got
    && state.wstate == status_sel_pkg::bus_idle;

  // Byte lanes as a bit mask
  always_comb
  begin
    wmask = '0;
    for (int i = 0; i < 4; i++)
      wmask[i*8 +: 8] = {8{state.wstrb[i]}};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] merged;
    logic [2:0] ev;
    merged = '0;
    ev = '0;
    next_state = state;

    // Write address and data taken in either order
    if (s_axi_awvalid && !state.aw_got)
    begin
      next_state.aw_got = 1'b1;
      next_state.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_got)
    begin
      next_state.w_got = 1'b1;
      next_state.wdata = s_axi_wdata;
      next_state.wstrb = s_axi_wstrb;
    end

    // Commit write once both halves are in
    if (do_write)
    begin
      next_state.wstate = status_sel_pkg::bus_resp;
      next_state.bresp = 2'b00;
      case (state.awaddr)
        `REG_CTRL:
        begin
          merged = ({21'h0, state.relay_sel, state.sel2,
            state.sel1} & ~wmask) | (state.wdata & wmask);
          // out-of-range codes are stored, output stays open
          next_state.sel1 = merged[`CTRL_SEL1_LSB +: 4];
          next_state.sel2 = merged[`CTRL_SEL2_LSB +: 4];
          next_state.relay_sel = merged[`CTRL_RELAY_LSB +: 3];
        end
        `REG_FREQ:
        begin
          merged = ({20'h0, state.desired_freq_setpoint} & ~wmask)
            | (state.wdata & wmask);
          // setpoint above 400.0 Hz is refused
          if (merged[31:12] == '0 && merged[11:0] <= `FREQ_MAX)
            next_state.desired_freq_setpoint = merged[11:0];
          else
            next_state.bresp = 2'b10;
        end
        `REG_COUNT:
        begin
          merged = ({18'h0, state.count_start} & ~wmask)
            | (state.wdata & wmask);
          // Start value 1 to 9999
          if (merged[31:14] == '0 && merged[13:0] != '0
            && merged[13:0] <= `COUNT_MAX)
            next_state.count_start = merged[13:0];
          else
            next_state.bresp = 2'b10;
        end
        `REG_IRQ_STAT:
          ; // Clearing handled below so that a new event wins
        `REG_IRQ_MASK:
          if (state.wstrb[0])
            next_state.irq_mask = state.wdata[2:0];
        `REG_STAT:
          next_state.bresp = 2'b10;
        default:
          next_state.bresp = 2'b11;
      endcase
    end

    // Response handshake
    if (state.wstate == status_sel_pkg::bus_resp && s_axi_bready)
    begin
      next_state.wstate = status_sel_pkg::bus_idle;
      next_state.aw_got = 1'b0;
      next_state.w_got = 1'b0;
    end

    // Read path: one cycle to data
    if (state.rstate == status_sel_pkg::bus_idle && s_axi_arvalid)
    begin
      next_state.rstate = status_sel_pkg::bus_resp;
      next_state.rresp = 2'b00;
      case (s_axi_araddr)
        `REG_CTRL:
          next_state.rdata = {21'h0, state.relay_sel, state.sel2,
            state.sel1};
        `REG_FREQ:
          next_state.rdata = {20'h0, state.desired_freq_setpoint};
        `REG_COUNT:
          next_state.rdata = {18'h0, state.count_start};
        `REG_STAT:
          next_state.rdata = {2'h0, state.counter, 1'b0, state.relay,
            state.out2, state.out1, 2'h0, state.cond_q};
        `REG_IRQ_STAT:
          next_state.rdata = {29'h0, state.irq_stat};
        `REG_IRQ_MASK:
          next_state.rdata = {29'h0, state.irq_mask};
        default:
        begin
          next_state.rdata = '0;
          next_state.rresp = 2'b11;
        end
      endcase
    end
    else if (state.rstate == status_sel_pkg::bus_resp && s_axi_rready)
      next_state.rstate = status_sel_pkg::bus_idle;

    // countdown on each trigger, reload after completion
    if (trig_rise)
    begin
      if (state.count_done)
      begin
        next_state.count_done = 1'b0;
        next_state.counter = state.count_start;
      end
      else if (state.counter <= `COUNT_DONE)
      begin
        next_state.count_done = 1'b1;
        next_state.counter = `COUNT_DONE;
      end
      else
      begin
        next_state.counter = state.counter - 14'h0001;
        if (state.counter - 14'h0001 == `COUNT_DONE)
          next_state.count_done = 1'b1;
      end
    end

    next_state.cond_q = cond;
    next_state.out1 = (state.sel1 <= `OUT_CODE_MAX) && cond[state.sel1];
    next_state.out2 = (state.sel2 <= `OUT_CODE_MAX) && cond[state.sel2];
    // relay map, code 0 is the fault indication
    case (state.relay_sel)
      3'h0: next_state.relay = cond[status_sel_pkg::cond_fault];
      3'h1: next_state.relay = cond[status_sel_pkg::cond_running];
      3'h2: next_state.relay = cond[status_sel_pkg::cond_freq_reached];
      3'h3: next_state.relay = cond[status_sel_pkg::cond_desired];
      3'h4: next_state.relay = cond[status_sel_pkg::cond_nonzero];
      3'h5: next_state.relay = cond[status_sel_pkg::cond_torque];
      3'h6: next_state.relay = cond[status_sel_pkg::cond_blocked];
      default: next_state.relay = 1'b0;
    endcase

    // Events: rising edges of each output; set wins over clear
    ev = {next_state.relay & ~state.relay, next_state.out2 & ~state.out2,
      next_state.out1 & ~state.out1};
    if (do_write && state.awaddr == `REG_IRQ_STAT && state.wstrb[0])
      next_state.irq_stat = state.irq_stat & ~state.wdata[2:0];
    next_state.irq_stat = next_state.irq_stat | ev;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= '0;
      state.sel1 <= `SEL1_RESET;
      state.sel2 <= `SEL2_RESET;
      state.relay_sel <= `RELAY_RESET;
      state.desired_freq_setpoint <= `FREQ_RESET;
      state.count_start <= `COUNT_RESET;
      state.counter <= `COUNT_RESET;
    end
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !state.aw_got;
  assign s_axi_wready = !state.w_got;
  assign s_axi_bvalid = state.wstate == status_sel_pkg::bus_resp;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = state.rstate == status_sel_pkg::bus_idle;
  assign s_axi_rvalid = state.rstate == status_sel_pkg::bus_resp;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign status_output_one = state.out1;
  assign status_output_two = state.out2;
  assign relay_normally_open_contact = state.relay;
  assign relay_normally_closed_contact = !state.relay;
  assign irq = |(state.irq_stat & state.irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence run_seen;
    forward_run_cmd && state.sel1 == 4'h0;
  endsequence

  run_out_a: assert property (run_seen |=> status_output_one)
    else $error("run command did not close output one");
  reset_sel_a: assert property ($rose(aresetn) |-> state.sel1 == 4'h0
    && state.sel2 == 4'h1)
    else $error("selector reset values wrong");
  bad_code_a: assert property (state.sel2 > 4'h9 |=> !status_output_two)
    else $error("invalid code closed output two");
  torque_out_a: assert property (state.sel1 == 4'h5 && $stable(state.sel1)
    |-> status_output_one == $past(over_torque))
    else $error("output one does not follow over-torque");
  fault_rst_a: assert property (restart_active && state.relay_sel == 3'h0
    |=> !relay_normally_open_contact)
    else $error("fault shown during restart");
  relay_comp_a: assert property (relay_normally_open_contact
    != relay_normally_closed_contact)
    else $error("relay contacts not complementary");
  setpoint_max_a: assert property (state.desired_freq_setpoint
    <= `FREQ_MAX)
    else $error("setpoint above maximum");
  reload_cnt_a: assert property (trig_rise && state.count_done
    |=> state.counter == $past(state.count_start) && !state.count_done)
    else $error("counter did not reload");
  done_cnt_a: assert property (state.count_done
    |-> state.counter == `COUNT_DONE)
    else $error("done without count one");
  nonzero_a: assert property (state.sel2 == 4'h4 && $stable(state.sel2)
    && $past(output_freq) <= $past(min_output_freq_setting)
    |-> !status_output_two)
    else $error("non-zero closed at minimum");

endmodule : status_output_selector

//--- status_contact_reader.sv
// Lamp and contact reader standing at the relay contact pins
module status_contact_reader
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Relay contacts as wired to the lamps
  input wire logic relay_no,
  input wire logic relay_nc,
  // Sticky flag: both or neither contact seen closed
  output logic contact_fault
);
  // ----------------------------------------------------------------
  // Contact watch
  // ----------------------------------------------------------------
  // complementary contacts watched
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      contact_fault <= 1'b0;
    else
      contact_fault <= contact_fault | (relay_no ~^ relay_nc);
  end
endmodule : status_contact_reader

//--- status_output_selector_bench.sv
// Self-checking bench of the status output selector
`include "status_sel_regs.svh"
module status_output_selector_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk = 0, aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // Condition inputs, baseline keeps every code open once the setpoint is above 0.5 Hz
  logic [11:0] output_freq = 12'h005, command_freq = 12'h006;
  logic [11:0] min_freq = 12'h00a;
  logic output_active = 0, forward_run_cmd = 0, reverse_run_cmd = 0;
  logic over_torque = 0, output_blocked = 0, low_voltage = 0;
  logic remote_mode = 0, fault_latched = 0, restart_active = 0;
  logic trig = 0;
  logic out1, out2, rno, rnc, contact_fault;
  int n_mismatch = 0, compares = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  // Table rows: condition, output code, relay code, relay closes
  typedef struct {int k; logic [3:0] code; logic [2:0] rly; logic on;} row_s;
  row_s rows[11] = '{'{0, 4'h0, 3'h1, 1'b1}, '{10, 4'h0, 3'h1, 1'b1},
    '{11, 4'h0, 3'h1, 1'b1}, '{1, 4'h1, 3'h2, 1'b1},
    '{2, 4'h2, 3'h3, 1'b1}, '{4, 4'h4, 3'h4, 1'b1},
    '{5, 4'h5, 3'h5, 1'b1}, '{6, 4'h6, 3'h6, 1'b1},
    '{7, 4'h7, 3'h7, 1'b0}, '{8, 4'h8, 3'h7, 1'b0},
    '{9, 4'h9, 3'h0, 1'b1}};
  // Clock, 100 ns period
  initial
  begin
    forever #50 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  status_output_selector dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .output_freq(output_freq),
    .command_freq(command_freq), .min_output_freq_setting(min_freq),
    .output_active(output_active), .forward_run_cmd(forward_run_cmd),
    .reverse_run_cmd(reverse_run_cmd), .over_torque(over_torque),
    .output_blocked(output_blocked), .low_voltage(low_voltage),
    .remote_mode(remote_mode), .fault_latched(fault_latched),
    .restart_active(restart_active), .count_trigger_input(trig),
    .status_output_one(out1), .status_output_two(out2),
    .relay_normally_open_contact(rno),
    .relay_normally_closed_contact(rnc), .irq(irq));
  status_contact_reader lamps (.aclk(aclk), .aresetn(aresetn),
    .relay_no(rno), .relay_nc(rnc), .contact_fault(contact_fault));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // Compare, four-state exact
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Write: both halves offered together, each dropped when taken
  task axw(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (wvalid && wready)
      begin
        w_ok = 1;
        wvalid <= 0;
      end
    end
    // Hold bready until the answer is sampled
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 0;
    // Let an edge pass so a following call never re-raises at once
    cyc(1);
  endtask : axw
  // Read: address held until taken, rready until data seen
  task axr(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    rd = rdata;
    resp = rresp;
    rready <= 0;
    cyc(1);
  endtask : axr
  // Raise or drop one condition; a table index picks which
  task set_cond(input int k, input logic v);
    case (k)
      0: forward_run_cmd <= v;
      1: command_freq <= v ? 12'h005 : 12'h006;
      2: output_freq <= v ? 12'hfa0 : 12'h005;
      // Equal to the minimum must stay open
      4: output_freq <= v ? 12'h00b : 12'h00a;
      5: over_torque <= v;
      6: output_blocked <= v;
      7: low_voltage <= v;
      8: remote_mode <= v;
      9: fault_latched <= v;
      10: output_active <= v;
      default: reverse_run_cmd <= v;
    endcase
  endtask : set_cond
  // Trigger pulse, wider and further apart than the synchroniser needs
  task pulse;
    trig <= 1;
    cyc(6);
    trig <= 0;
    cyc(8);
  endtask : pulse
  // Verdict, reached from the main sequence or the watchdog
  task summarize;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Watchdog, far beyond the few hundred cycles the tests take
  // ----------------------------------------------------------------
  initial
  begin
    cyc(20000);
    n_mismatch++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    cyc(4);
    aresetn <= 1;
    cyc(1);
    chk(out1, 1'b0);
    chk(rnc, 1'b1);
    axr(`REG_CTRL);
    chk(rd, 32'h00000010);
    axr(`REG_FREQ);
    chk(rd, 32'h0);
    $display("test reset done");
    // Setpoint range: top accepted, one above refused
    axw(`REG_FREQ, 32'h00000fa1);
    chk(resp, 2'b10);
    axw(`REG_FREQ, 32'h00000fa0);
    chk(resp, 2'b00);
    axr(`REG_FREQ);
    chk(rd, 32'h00000fa0);
    axr(12'h020);
    chk(resp, 2'b11);
    chk(rd, 32'h0);
    $display("test setpoint done");
    // One row per condition source except the countdown, both outputs and the relay together
    foreach (rows[i])
    begin
      set_cond(rows[i].k, 0);
      axw(`REG_CTRL, {21'h0, rows[i].rly, rows[i].code, rows[i].code});
      cyc(3);
      chk({out1, out2, rno, rnc}, 4'b0001);
      set_cond(rows[i].k, 1);
      cyc(3);
      // Codes of both outputs and the relay
      chk({out1, out2}, 2'b11);
      chk({rno, rnc}, {rows[i].on, !rows[i].on});
      set_cond(rows[i].k, 0);
      // Next row drives its own input only after an edge
      cyc(1);
    end
    $display("test code table done");
    // Restart hides the fault; out-of-range code stays open
    axw(`REG_CTRL, 32'h00000099);
    fault_latched <= 1;
    restart_active <= 1;
    cyc(3);
    chk({out1, rno, rnc}, 3'b001);
    restart_active <= 0;
    cyc(3);
    chk({out1, rno, rnc}, 3'b110);
    forward_run_cmd <= 1;
    axw(`REG_CTRL, 32'h000007ff);
    cyc(3);
    chk({out1, out2}, 2'b00);
    fault_latched <= 0;
    forward_run_cmd <= 0;
    $display("test fault done");
    // Countdown: start 1, then reload to 2 after completion
    axw(`REG_CTRL, 32'h00000733);
    cyc(3);
    chk(out1, 1'b0);
    pulse();
    chk(out1, 1'b1);
    pulse();
    chk(out1, 1'b0);
    pulse();
    chk(out2, 1'b1);
    axw(`REG_COUNT, 32'h0);
    chk(resp, 2'b10);
    axw(`REG_COUNT, 32'h00000002);
    pulse();
    chk(out1, 1'b0);
    pulse();
    chk(out1, 1'b1);
    // Status word: counter at one, both outputs closed, done condition
    axr(`REG_STAT);
    chk(rd, 32'h00013008);
    $display("test countdown done");
    // Interrupt: rises latched, masked off, then cleared
    axr(`REG_IRQ_STAT);
    chk(rd, 32'h00000007);
    chk(irq, 1'b0);
    axw(`REG_IRQ_MASK, 32'h00000001);
    cyc(2);
    chk(irq, 1'b1);
    axw(`REG_IRQ_STAT, 32'h00000007);
    cyc(2);
    chk(irq, 1'b0);
    axr(`REG_IRQ_STAT);
    chk(rd, 32'h0);
    chk(contact_fault, 1'b0);
    $display("test interrupt done");
    summarize();
  end
endmodule : status_output_selector_bench
